// [rtl/hfc_pkg.sv]
// Purpose: Shared constants for the hold-off fail-over counter block
// Assumes: 32-bit classic Wishbone register bus, word-aligned registers
// Notes: Register offsets are byte addresses
`default_nettype none
package hfc_pkg;
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] HOLD_OFS = 4'h4;
    localparam logic [3:0] STAT_OFS = 4'h8;
    // Control register fields
    localparam int MODE_LSB = 0;
    localparam int SEL_LSB = 2;
    localparam int DIV_LSB = 4;
    // Reset values
    localparam logic [1:0] MODE_RST = 2'h0;
    localparam logic [1:0] SEL_RST = 2'h0;
    localparam logic [1:0] DIV_RST = 2'h2;
    localparam logic [7:0] HOLD_RST = 8'h80;
    // Selection mode codes
    localparam logic [1:0] MODE_AUTO_HOLD = 2'h3;
    // Tick divider exponents, powers of two of the VCXO pulse train
    localparam int DIV_EXP_0 = 15;
    localparam int DIV_EXP_1 = 16;
    localparam int DIV_EXP_2 = 17;
    localparam int PRE_W = 17;
    typedef enum logic [1:0] {
        HFC_IDLE = 2'b01,
        HFC_COUNT = 2'b10
    } hfc_state_e;
endpackage : hfc_pkg
`default_nettype wire

// [rtl/hfc_top.sv]
// Purpose: Hold-off down-counter that requests a reference fail-over
// Assumes: vcxo_pulse_i is a one-cycle pulse per VCXO output period,
//          synchronous to clk_i; los_i and active_ref_i are synchronous
// Notes: Single clock; divider ticks are counted from the VCXO pulse input
// Operation
// - Manual modes select reference by select field
// - Counter runs only in automatic-with-holdover mode
// - Loss of signal starts countdown from setting
// - Zero transition requests switch to another input
// - One decrement per divided VCXO tick
// - Reload setting after every zero transition
// - Divider 2^15/2^16/2^17, reset code 10
//
// Decided for this implementation: the Wishbone interface to the registers and the placing of the registers.
`default_nettype none
module hfc_top #(
    // Width of the hold-off counter and its setting register
    parameter int HOLD_W = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Reference monitoring
    input wire logic vcxo_pulse_i,
    input wire logic [3:0] los_i,
    input wire logic [1:0] active_ref_i,
    // Selection outputs
    output logic [1:0] ref_sel_o,
    output logic failover_req_o
);
    import hfc_pkg::*;

    // The status word and bus decode only fit the 8-bit counter
    if (HOLD_W != 8) begin : g_width_check
        $error("Hold-off counter width must be 8");
    end

    logic [1:0] ref_selection_mode;
    logic [1:0] ref_select;
    logic [1:0] holdoff_tick_divider;
    logic [7:0] holdoff_period_setting;
    logic [7:0] holdoff_cnt;
    logic [PRE_W-1:0] pre_cnt;
    logic [3:0] los_q;
    hfc_state_e state;

    function automatic logic [PRE_W-1:0] div_mask(input logic [1:0] code);
        unique case (code)
            2'h0: div_mask = PRE_W'((1 << DIV_EXP_0) - 1);
            2'h1: div_mask = PRE_W'((1 << DIV_EXP_1) - 1);
            default: div_mask = PRE_W'((1 << DIV_EXP_2) - 1);
        endcase
    endfunction : div_mask

    // Bus decode
    wire access = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wr_lo = access && wb_we_i && wb_sel_i[0];
    wire hit_ctrl = wb_adr_i == CTRL_OFS;
    wire hit_hold = wb_adr_i == HOLD_OFS;
    wire hit_stat = wb_adr_i == STAT_OFS;
    wire [31:0] ctrl_word = {26'h0, holdoff_tick_divider, ref_select, ref_selection_mode};
    wire [31:0] stat_word = {21'h0, state == HFC_COUNT, active_ref_i, holdoff_cnt};
    wire [31:0] rd_word = hit_ctrl ? ctrl_word :
                          hit_hold ? {24'h0, holdoff_period_setting} :
                          hit_stat ? stat_word : 32'h0;

    // Hold-off timing decode
    wire auto_hold = ref_selection_mode == MODE_AUTO_HOLD;
    wire [PRE_W-1:0] mask = div_mask(holdoff_tick_divider);
    wire tick = vcxo_pulse_i && ((pre_cnt & mask) == mask);
    wire los_rise = los_i[active_ref_i] && !los_q[active_ref_i];
    wire start = auto_hold && state == HFC_IDLE && los_rise;
    wire counting = auto_hold && state == HFC_COUNT;
    wire hit_zero = counting && tick && holdoff_cnt <= 8'h01;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= access;
            wb_dat_o <= access ? rd_word : 32'h0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ref_selection_mode <= MODE_RST;
            ref_select <= SEL_RST;
            holdoff_tick_divider <= DIV_RST;
        end else if (wr_lo && hit_ctrl) begin
            ref_selection_mode <= wb_dat_i[MODE_LSB +: 2];
            ref_select <= wb_dat_i[SEL_LSB +: 2];
            holdoff_tick_divider <= wb_dat_i[DIV_LSB +: 2];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            holdoff_period_setting <= HOLD_RST;
        end else if (wr_lo && hit_hold) begin
            holdoff_period_setting <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            los_q <= 4'h0;
        end else begin
            los_q <= los_i;
        end
    end

    // Prescaler restarts with each countdown so the first tick is a full period
    always_ff @(posedge clk_i) begin
        if (rst_i || start) begin
            pre_cnt <= '0;
        end else if (vcxo_pulse_i) begin
            pre_cnt <= (pre_cnt & mask) == mask ? '0 : pre_cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= HFC_IDLE;
        end else if (!auto_hold || hit_zero) begin
            state <= HFC_IDLE;
        end else if (start) begin
            state <= HFC_COUNT;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            holdoff_cnt <= HOLD_RST;
        end else if (start || hit_zero) begin
            holdoff_cnt <= holdoff_period_setting;
        end else if (counting && tick) begin
            holdoff_cnt <= holdoff_cnt - 8'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            failover_req_o <= 1'b0;
            ref_sel_o <= SEL_RST;
        end else begin
            failover_req_o <= hit_zero;
            ref_sel_o <= ref_selection_mode[0] ? active_ref_i : ref_select;
        end
    end

    // Checks
    mode_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !auto_hold |=> state == HFC_IDLE && !failover_req_o)
        else $error("Hold-off active outside automatic holdover mode");
    los_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
        start |=> state == HFC_COUNT && holdoff_cnt == $past(holdoff_period_setting))
        else $error("Countdown did not start on loss of signal");
    zero_fail_a: assert property (@(posedge clk_i) disable iff (rst_i)
        counting && tick && holdoff_cnt == 8'h01 |=> failover_req_o ##1 !failover_req_o)
        else $error("No single fail-over pulse at zero transition");
    tick_dec_a: assert property (@(posedge clk_i) disable iff (rst_i)
        counting && tick && holdoff_cnt > 8'h01 |=> holdoff_cnt == $past(holdoff_cnt) - 8'h01)
        else $error("Counter did not decrement on tick");
    hold_still_a: assert property (@(posedge clk_i) disable iff (rst_i)
        counting && !tick |=> $stable(holdoff_cnt))
        else $error("Counter moved without a tick");
    reload_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(failover_req_o) |-> holdoff_cnt == $past(holdoff_period_setting) && state == HFC_IDLE)
        else $error("Counter not reloaded after zero transition");
    tick_span_a: assert property (@(posedge clk_i) disable iff (rst_i)
        tick |-> pre_cnt[DIV_EXP_0-1:0] == 15'h7FFF && (holdoff_tick_divider == 2'h0 || pre_cnt[15]))
        else $error("Tick outside divider period");
    code_three_a: assert property (@(posedge clk_i) disable iff (rst_i)
        holdoff_tick_divider == 2'h3 && tick |-> pre_cnt[16])
        else $error("Reserved divider code not at largest divisor");
    manual_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !ref_selection_mode[0] |=> ref_sel_o == $past(ref_select))
        else $error("Manual reference select not followed");
    ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("Bus acknowledge longer than one cycle");

    // Bus checks
    ack_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
        access |=> wb_ack_o)
        else $error("Taken access not acknowledged next cycle");

    ack_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !access |=> !wb_ack_o)
        else $error("Acknowledge without a taken access");

    dat_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("Read data not zero outside acknowledge");

    rd_ctrl_a: assert property (@(posedge clk_i) disable iff (rst_i)
        access && !wb_we_i && hit_ctrl |=> wb_dat_o == $past(ctrl_word))
        else $error("Control read data wrong");

    rd_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        access && !wb_we_i && hit_hold |=> wb_dat_o[7:0] == $past(holdoff_period_setting))
        else $error("Setting read data wrong");

    rd_stat_a: assert property (@(posedge clk_i) disable iff (rst_i)
        access && !wb_we_i && hit_stat |=> wb_dat_o == $past(stat_word))
        else $error("Status read data wrong");

    rd_unmapped_a: assert property (@(posedge clk_i) disable iff (rst_i)
        access && !hit_ctrl && !hit_hold && !hit_stat |=> wb_dat_o == 32'h0)
        else $error("Unmapped read not zero");

    wr_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_lo && hit_hold |=> holdoff_period_setting == $past(wb_dat_i[7:0]))
        else $error("Setting write lost");

    wr_ctrl_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_lo && hit_ctrl |=> ctrl_word[5:0] == $past(wb_dat_i[5:0]))
        else $error("Control write lost");

    sel_guard_a: assert property (@(posedge clk_i) disable iff (rst_i)
        access && wb_we_i && !wb_sel_i[0] |=> $stable(ctrl_word) && $stable(holdoff_period_setting))
        else $error("Write without low byte enable took effect");

    div_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !(wr_lo && hit_ctrl) |=> $stable(holdoff_tick_divider))
        else $error("Divider code changed without a write");

    hold_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !(wr_lo && hit_hold) |=> $stable(holdoff_period_setting))
        else $error("Setting changed without a write");

    ack_no_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> $stable(ctrl_word))
        else $error("Control written during acknowledge");

    // Selection checks
    auto_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ref_selection_mode[0] |=> ref_sel_o == $past(active_ref_i))
        else $error("Automatic reference not passed through");

    // Hold-off checks
    idle_still_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state == HFC_IDLE && !start |=> $stable(holdoff_cnt))
        else $error("Counter moved while idle");

    fail_single_a: assert property (@(posedge clk_i) disable iff (rst_i)
        failover_req_o |=> !failover_req_o)
        else $error("Fail-over request longer than one cycle");

    fail_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
        failover_req_o |-> $past(counting))
        else $error("Fail-over request without countdown");

    idle_no_fail_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state == HFC_IDLE |=> !failover_req_o)
        else $error("Fail-over request from idle");

    los_ignored_a: assert property (@(posedge clk_i) disable iff (rst_i)
        counting && los_rise && !hit_zero |=> state == HFC_COUNT)
        else $error("Loss of signal disturbed a running countdown");

    count_stays_a: assert property (@(posedge clk_i) disable iff (rst_i)
        counting && !hit_zero |=> state == HFC_COUNT)
        else $error("Countdown left early");

    zero_reload_a: assert property (@(posedge clk_i) disable iff (rst_i)
        hit_zero |=> holdoff_cnt == $past(holdoff_period_setting))
        else $error("No reload at zero transition");

    state_legal_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state == HFC_IDLE || state == HFC_COUNT)
        else $error("Illegal countdown state");

    // Prescaler checks
    pre_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        start |=> pre_cnt == '0)
        else $error("Prescaler not cleared at countdown start");

    pre_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !vcxo_pulse_i && !start |=> $stable(pre_cnt))
        else $error("Prescaler moved without a VCXO pulse");

    pre_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
        vcxo_pulse_i && !start && (pre_cnt & mask) != mask
        |=> pre_cnt == $past(pre_cnt) + 1'b1)
        else $error("Prescaler did not step on a VCXO pulse");

    tick_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
        tick && !start |=> pre_cnt == '0)
        else $error("Prescaler did not wrap at tick");


    failover_c: cover property (@(posedge clk_i) disable iff (rst_i) failover_req_o);
    start_c: cover property (@(posedge clk_i) disable iff (rst_i) start);
    tick_c: cover property (@(posedge clk_i) disable iff (rst_i) counting && tick);
    write_c: cover property (@(posedge clk_i) disable iff (rst_i) wr_lo && hit_hold);
endmodule : hfc_top
`default_nettype wire

// [bench/holdoff_failover_counter_test.sv]
// Purpose: Self-checking bench for the hold-off fail-over counter
// Assumes: vcxo_pulse_i held high so one pulse arrives per clock
// Notes: Divider code 00 keeps a fail-over near 32768 cycles
`default_nettype none
module holdoff_failover_counter_test;
    timeunit 1ns;
    timeprecision 1ps;
    import hfc_pkg::*;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, vcxo = 0;
    logic [3:0] adr = 4'h0, sel = 4'h0, los = 4'h0;
    logic [31:0] dat = 32'h0, q, wb_dat_o;
    logic [1:0] act = 2'h0, ref_sel_o;
    logic wb_ack_o, failover_req_o;
    int n_mismatch = 0, total_checks = 0, n;
    always #4 clk_i = ~clk_i;
    hfc_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .vcxo_pulse_i(vcxo), .los_i(los), .active_ref_i(act),
        .ref_sel_o(ref_sel_o), .failover_req_o(failover_req_o));
    task automatic print_verdict;
        if (n_mismatch == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hF;
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        cyc <= 1'b0; stb <= 1'b0;
    endtask : bus
    task automatic reset_values;
        bus(0, CTRL_OFS, 0); chk(q, 32'h20);
        bus(0, HOLD_OFS, 0); chk(q, 32'h80);
        bus(0, STAT_OFS, 0); chk(q, 32'h80);
        bus(0, 4'hC, 0); chk(q, 32'h0);
        bus(1, CTRL_OFS, 32'h33); bus(0, CTRL_OFS, 0); chk(q, 32'h33);
    endtask : reset_values
    task automatic manual_select;
        for (int s = 0; s < 4; s++) begin
            bus(1, CTRL_OFS, 32'(s << SEL_LSB));
            repeat (2) @(posedge clk_i);
            chk(32'(ref_sel_o), 32'(s));
        end
    endtask : manual_select
    task automatic mode_refused;
        bus(1, CTRL_OFS, 32'h01);
        los <= 4'h1;
        repeat (3) @(posedge clk_i);
        bus(0, STAT_OFS, 0); chk(q & 32'h400, 32'h0);
        los <= 4'h0;
    endtask : mode_refused
    task automatic holdoff_run;
        bus(1, HOLD_OFS, 32'h1);
        bus(1, CTRL_OFS, 32'h03);
        vcxo <= 1'b1;
        @(posedge clk_i);
        los <= 4'h1;
        bus(0, STAT_OFS, 0); chk(q & 32'h4FF, 32'h401);
        bus(1, HOLD_OFS, 32'h5);
        n = 0;
        while (failover_req_o !== 1'b1 && n < 40000) begin
            @(posedge clk_i);
            n++;
        end
        chk(32'(n > 32740 && n < 32790), 32'h1);
        @(posedge clk_i);
        chk(32'(failover_req_o), 32'h0);
        bus(0, STAT_OFS, 0); chk(q & 32'h4FF, 32'h005);
    endtask : holdoff_run
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        reset_values();
        manual_select();
        mode_refused();
        holdoff_run();
        print_verdict();
    end
    initial begin
        repeat (60000) @(posedge clk_i);
        n_mismatch++;
        print_verdict();
    end
endmodule : holdoff_failover_counter_test
`default_nettype wire
